//--- hdl/scra_pkg.sv
// Types shared by the scope channel register access block.
// Assumes scra_regs.svh sits on the include path.
`include "scra_regs.svh"

package scra_pkg;

    // Control byte as seen in the output image
    typedef struct packed {
        logic mode;
        logic dir;
        logic [`SCRA_NUM_W-1:0] num;
    } scra_ctrl_t;

    // Status byte as returned in the input image
    typedef struct packed {
        logic ack;
        logic dir;
        logic [`SCRA_NUM_W-1:0] num;
    } scra_stat_t;

    // Output image of channel one for one exchange cycle
    typedef struct packed {
        scra_ctrl_t ctrl;
        logic [`SCRA_WORD_W-1:0] word0;
        logic [`SCRA_WORD_W-1:0] word1;
    } scra_out_img_t;

    typedef enum logic [1:0] {
        SCRA_IDLE,
        SCRA_ACCESS,
        SCRA_REPLY
    } scra_state_t;

endpackage : scra_pkg

//--- hdl/scra_reg_file.sv
// Register file of the first channel: 64 words, synchronous read and write.
// Assumes one access per cycle from the handshake logic; index registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "scra_regs.svh"

module scra_reg_file #(
    parameter int NUM_W = `SCRA_NUM_W,
    parameter int WORD_W = `SCRA_WORD_W
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Access port
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [NUM_W-1:0] addr_in,
    input wire logic [WORD_W-1:0] wdata_in,
    output logic [WORD_W-1:0] rdata_out,
    // Index registers steering process data
    output logic [WORD_W-1:0] idx1_out,
    output logic [WORD_W-1:0] idx2_out
);
    logic [WORD_W-1:0] mem [0:(1<<NUM_W)-1];
    logic [WORD_W-1:0] rdata_q, rdata_d;
    logic [WORD_W-1:0] idx1_q, idx1_d, idx2_q, idx2_d;

    // Memory words carry no reset; only the index registers and the read data register need a known value
    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_comb begin
        idx1_d = idx1_q;
        idx2_d = idx2_q;
        rdata_d = rdata_q;
        if (wr_en_in && addr_in == `SCRA_IDX1_REG) begin
            idx1_d = wdata_in;
        end else if (wr_en_in && addr_in == `SCRA_IDX2_REG) begin
            idx2_d = wdata_in;
        end
        if (rd_en_in) begin
            if (addr_in == `SCRA_IDX1_REG) begin
                rdata_d = idx1_q;
            end else if (addr_in == `SCRA_IDX2_REG) begin
                rdata_d = idx2_q;
            end else begin
                rdata_d = mem[addr_in];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            idx1_q <= `SCRA_WORD_RST;
            idx2_q <= `SCRA_WORD_RST;
            rdata_q <= `SCRA_WORD_RST;
        end else begin
            idx1_q <= idx1_d;
            idx2_q <= idx2_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign idx1_out = idx1_q;
    assign idx2_out = idx2_q;

endmodule : scra_reg_file
`default_nettype wire

//--- hdl/scra_regs.svh
// Bit positions, register numbers and reset values of the scope channel register access block.
// Definitions only; included by the package and the design modules.
`ifndef SCRA_REGS_SVH
`define SCRA_REGS_SVH

`define SCRA_MODE_BIT 7
`define SCRA_DIR_BIT 6
`define SCRA_NUM_MSB 5
`define SCRA_NUM_W 6
`define SCRA_WORD_W 16
`define SCRA_IDX1_REG 6'h26
`define SCRA_IDX2_REG 6'h27
`define SCRA_BYTE_RST 8'h00
`define SCRA_WORD_RST 16'h0000
`define SCRA_NUM_RST 6'h00

`endif

//--- hdl/scra_top.sv
// Process image handshake of a two-channel scope terminal: channel one switches between
// process data and register communication; channel two only acknowledges process data mode.
// Assumes the coupler presents the output image with a one-cycle exchange strobe.
//
// Function
// - Channel one control byte arrives each exchange
// - Channel one status byte driven back
// - Mode bit set selects register communication
// - Read returns addressed register in word zero
// - Write stores output word zero in register
// - Word one unused during register communication
// - Status acknowledges, shows direction, echoes number
// - Channel two control bits ignored
// - Channel two control byte drives nothing
// - Channel two status bit 7 reads 0
// - Channel two reserved status bits fixed zero
// - Process mode word zero from index one
// - Process mode status bit 7 reads 0
`timescale 1ns/1ps
`default_nettype none
`include "scra_regs.svh"

module scra_top #(
    parameter int SEL_W = 2,
    parameter int NUM_W = `SCRA_NUM_W,
    parameter int WORD_W = `SCRA_WORD_W
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Output image from the controller
    input wire logic exchange_in,
    input wire scra_pkg::scra_out_img_t out_img_in,
    input wire logic [7:0] channel2_control_byte_in,
    // Process values offered by the measuring side
    input wire logic [(1<<SEL_W)-1:0][WORD_W-1:0] proc_values_in,
    // Input image to the controller
    output scra_pkg::scra_stat_t channel1_status_byte_out,
    output logic [WORD_W-1:0] input_word_zero_out,
    output logic [WORD_W-1:0] input_word_one_out,
    output logic [7:0] channel2_status_byte_out
);
    scra_pkg::scra_state_t state_q, state_d;
    scra_pkg::scra_ctrl_t req_q, req_d;
    logic [WORD_W-1:0] wdata_q, wdata_d;
    scra_pkg::scra_stat_t stat_q, stat_d;
    logic [WORD_W-1:0] in0_q, in0_d, in1_q, in1_d;
    logic rd_en, wr_en;
    logic [WORD_W-1:0] rdata, idx1, idx2;

    // The second channel never enters register communication here, so its control
    // byte is not looked at at all.

    scra_reg_file #(
        .NUM_W(NUM_W),
        .WORD_W(WORD_W)
    ) u_reg_file (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .rd_en_in(rd_en),
        .wr_en_in(wr_en),
        .addr_in(req_q.num),
        .wdata_in(wdata_q),
        .rdata_out(rdata),
        .idx1_out(idx1),
        .idx2_out(idx2)
    );

    assign rd_en = (state_q == scra_pkg::SCRA_ACCESS) && !req_q.dir;
    assign wr_en = (state_q == scra_pkg::SCRA_ACCESS) && req_q.dir;

    always_comb begin
        state_d = state_q;
        req_d = req_q;
        wdata_d = wdata_q;
        stat_d = stat_q;
        in0_d = in0_q;
        in1_d = in1_q;
        case (state_q)
            scra_pkg::SCRA_IDLE: begin
                if (exchange_in) begin
                    req_d = out_img_in.ctrl;
                    wdata_d = out_img_in.word0;
                    if (out_img_in.ctrl.mode) begin
                        state_d = scra_pkg::SCRA_ACCESS;
                    end else begin
                        stat_d = `SCRA_BYTE_RST;
                        in0_d = proc_values_in[idx1[SEL_W-1:0]];
                        in1_d = proc_values_in[idx2[SEL_W-1:0]];
                    end
                end
            end
            scra_pkg::SCRA_ACCESS: begin
                state_d = scra_pkg::SCRA_REPLY;
            end
            scra_pkg::SCRA_REPLY: begin
                // Status echoes only now, once read data sit in word zero or the write is done
                stat_d.ack = 1'b1;
                stat_d.dir = req_q.dir;
                stat_d.num = req_q.num;
                if (!req_q.dir) begin
                    in0_d = rdata;
                end
                in1_d = `SCRA_WORD_RST;
                state_d = scra_pkg::SCRA_IDLE;
            end
            default: begin
                state_d = scra_pkg::SCRA_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= scra_pkg::SCRA_IDLE;
            req_q <= `SCRA_BYTE_RST;
            wdata_q <= `SCRA_WORD_RST;
            stat_q <= `SCRA_BYTE_RST;
            in0_q <= `SCRA_WORD_RST;
            in1_q <= `SCRA_WORD_RST;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            wdata_q <= wdata_d;
            stat_q <= stat_d;
            in0_q <= in0_d;
            in1_q <= in1_d;
        end
    end

    assign channel1_status_byte_out = stat_q;
    assign input_word_zero_out = in0_q;
    assign input_word_one_out = in1_q;
    assign channel2_status_byte_out = `SCRA_BYTE_RST;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence reg_req_s;
        (state_q == scra_pkg::SCRA_IDLE) && exchange_in && out_img_in.ctrl.mode;
    endsequence

    sequence proc_req_s;
        (state_q == scra_pkg::SCRA_IDLE) && exchange_in && !out_img_in.ctrl.mode;
    endsequence

    reg_mode_entry_a: assert property (reg_req_s |=> state_q == scra_pkg::SCRA_ACCESS)
        else $error("register request did not start an access");

    reg_echo_timing_a: assert property (reg_req_s |-> ##3 (channel1_status_byte_out.ack
        && channel1_status_byte_out.num == $past(out_img_in.ctrl.num, 3)
        && channel1_status_byte_out.dir == $past(out_img_in.ctrl.dir, 3)))
        else $error("status did not echo the request three cycles later");

    echo_after_done_a: assert property ($rose(channel1_status_byte_out.ack)
        |-> $past(state_q) == scra_pkg::SCRA_REPLY)
        else $error("acknowledge appeared before the access finished");

    write_store_a: assert property ((reg_req_s and out_img_in.ctrl.dir)
        |-> ##1 (wr_en && wdata_q == $past(out_img_in.word0)))
        else $error("write did not store output word zero");

    read_return_a: assert property ((state_q == scra_pkg::SCRA_REPLY) && !req_q.dir
        |=> input_word_zero_out == $past(rdata))
        else $error("read data missing from word zero");

    word_one_idle_a: assert property ((state_q == scra_pkg::SCRA_REPLY)
        |=> input_word_one_out == `SCRA_WORD_RST)
        else $error("word one carried data during register access");

    proc_ack_a: assert property (proc_req_s |=> (!channel1_status_byte_out.ack
        && input_word_zero_out == $past(proc_values_in[idx1[SEL_W-1:0]])))
        else $error("process mode reply wrong");

    ch2_status_a: assert property (channel2_status_byte_out == `SCRA_BYTE_RST)
        else $error("channel two status not zero");

endmodule : scra_top
`default_nettype wire

//--- sim/scra_coupler.sv
// Bus coupler model: relays one controller output image per exchange strobe.
// Assumes every cycle with send_in high is one exchange.
`timescale 1ns/1ps
`default_nettype none

module scra_coupler (
    // Request from the controller side
    input wire logic send_in,
    input wire scra_pkg::scra_out_img_t img_in,
    // Output image towards the terminal
    output logic exchange_out,
    output scra_pkg::scra_out_img_t out_img_out
);
    assign exchange_out = send_in;
    // Image is only valid with the strobe; show the inverse so stale data never looks valid
    assign out_img_out = send_in ? img_in : ~img_in;
endmodule : scra_coupler

`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the scope channel register access block.
// Assumes the coupler model in sim/ and the design and headers under hdl/.
`timescale 1ns/1ps
`default_nettype none
`include "scra_regs.svh"

module testbench;
    logic ref_clk_in;
    logic rst_in;
    logic send;
    scra_pkg::scra_out_img_t img;
    logic exchange;
    scra_pkg::scra_out_img_t out_img;
    logic [7:0] ctrl2;
    logic [3:0][15:0] pv;
    scra_pkg::scra_stat_t stat;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [7:0] stat2;
    int n_errors;
    int checks_done;
    int cycles = 0;

    scra_coupler scra_coupler_inst (.send_in(send), .img_in(img),
        .exchange_out(exchange), .out_img_out(out_img));

    scra_top scra_top_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .exchange_in(exchange), .out_img_in(out_img), .channel2_control_byte_in(ctrl2),
        .proc_values_in(pv), .channel1_status_byte_out(stat),
        .input_word_zero_out(word0), .input_word_one_out(word1),
        .channel2_status_byte_out(stat2));

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // The whole sequence needs well under 200 cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Word one carries junk: the terminal must not depend on it.
    // Strobe stays up on return, so back-to-back exchanges never toggle it in one step.
    task automatic send_img(input logic [7:0] ctrl, input logic [15:0] w0);
        img = {ctrl, w0, ~w0};
        send = 1'b1;
        @(posedge ref_clk_in);
        #2;
    endtask : send_img

    task automatic reg_access(input logic dir, input logic [5:0] num,
                              input logic [15:0] w0, input logic [15:0] exp0);
        send_img({1'b1, dir, num}, w0);
        send = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #2;
        check(stat, {1'b1, dir, num});
        check(word1, 16'h0000);
        if (!dir) begin
            check(word0, exp0);
        end
    endtask : reg_access

    task automatic proc_xchg(input logic [7:0] c2, input logic [15:0] e0,
                             input logic [15:0] e1);
        ctrl2 = c2;
        send_img({1'b0, c2[6:0]}, 16'hffff);
        check(stat, 8'h00);
        check(word0, e0);
        check(word1, e1);
        check(stat2, 8'h00);
    endtask : proc_xchg

    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        n_errors = 0;
        checks_done = 0;
        rst_in = 1'b1;
        send = 1'b0;
        img = '0;
        ctrl2 = 8'h00;
        pv = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
        repeat (12) @(posedge ref_clk_in);
        #2;
        rst_in = 1'b0;
        check(stat, 8'h00);
        proc_xchg(8'h00, 16'h1111, 16'h1111);
        reg_access(1'b1, `SCRA_IDX1_REG, 16'h0002, 16'h0000);
        reg_access(1'b1, `SCRA_IDX2_REG, 16'h0003, 16'h0000);
        reg_access(1'b1, 6'h05, 16'ha5c3, 16'h0000);
        reg_access(1'b1, 6'h3f, 16'h5a3c, 16'h0000);
        reg_access(1'b0, 6'h05, 16'h0000, 16'ha5c3);
        reg_access(1'b0, 6'h3f, 16'h0000, 16'h5a3c);
        reg_access(1'b0, `SCRA_IDX1_REG, 16'h0000, 16'h0002);
        // Back-to-back process exchanges, channel two byte from 8'hff shifted right one bit each step
        for (int i = 0; i < 4; i++) begin
            pv[2] = pv[2] + 16'h0101;
            proc_xchg(8'hff >> i, pv[2], pv[3]);
        end
        stop_test();
    end
endmodule : testbench

`default_nettype wire
